// file: status_ops_defs.vh
// Constants for the status clear, rotate and return instruction block
`ifndef STATUS_OPS_DEFS_VH
`define STATUS_OPS_DEFS_VH
// ====================================================================
// Opcodes
`define OPC_CARRY_CLEAR 16'hCE30
`define OPC_SUB_EXIT 16'hCE26
`define OPC_FSYNC_CLEAR 16'hCE36
`define OPC_HOLD_CLEAR 16'hCE38
`define OPC_ROT_LEFT 16'hCE34
`define OPC_ROT_RIGHT 16'hCE35
// ====================================================================
// APB register byte offsets
`define REG_CTRL 12'h000
`define REG_INSTR 12'h004
`define REG_ACC 12'h008
`define REG_PC 12'h00C
`define REG_STATUS 12'h010
`define REG_STACK_TOP 12'h014
`define REG_STACK_DEPTH 12'h018
// ====================================================================
// Status word one fields
`define ST_CARRY 0
`define ST_FSYNC 1
`define ST_HOLD 2
// ====================================================================
// Reset values
`define RST_STATUS 3'h7
`define RST_PC 16'h0000
`define RST_ACC 32'h00000000
`define RST_CARRY 1'b1
`define RST_FSYNC 1'b1
`define RST_HOLD 1'b1
`define RST_INSTR 16'h0000
`define RST_DEPTH 4'h0
`endif

// file: hw_stack.v
// Eight-level last-in first-out hardware return stack
`timescale 1ns/1ps
`default_nettype none
module hw_stack #(
	parameter DEPTH = 8,
	parameter WIDTH = 16
) (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire push,
	input wire pop,
	input wire [WIDTH-1:0] push_data,
	output wire [WIDTH-1:0] stack_top_entry
);
	reg [WIDTH-1:0] ent_q [0:DEPTH-1];
	integer i;
	assign stack_top_entry = ent_q[0];
	// ====================================================================
	// Shift register stack
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < DEPTH; i = i + 1)
				ent_q[i] <= {WIDTH{1'b0}};
		end
		else if (ce)
		begin
			if (push)
			begin
				ent_q[0] <= push_data;
				for (i = 1; i < DEPTH; i = i + 1)
					ent_q[i] <= ent_q[i-1];
			end
			else if (pop)
			begin
				for (i = 0; i < DEPTH-1; i = i + 1)
					ent_q[i] <= ent_q[i+1];
			end
		end
	end
endmodule // hw_stack
`default_nettype wire

// file: status_clear_rotate_return_ops.v
// Executes clear, rotate and return instructions under APB control
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "status_ops_defs.vh"
module status_clear_rotate_return_ops #(
	parameter STACK_DEPTH = 8
) (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire hold_ack,
	output wire frame_sync_mode_bit,
	output wire hold_mode_bit,
	output wire exec_enable
);
	// ====================================================================
	// Registers and next values
	reg [31:0] acc_q;
	reg [31:0] acc_d;
	reg [15:0] pc_q;
	reg [15:0] pc_d;
	reg carry_q;
	reg carry_d;
	reg fsync_q;
	reg fsync_d;
	reg hold_q;
	reg hold_d;
	reg [15:0] instr_q;
	reg [15:0] instr_d;
	reg [3:0] depth_q;
	reg [3:0] depth_d;
	reg [31:0] prdata_d;
	reg err_d;
	// ====================================================================
	// Internal nets
	wire [2:0] status_word_one;
	wire [15:0] stack_top_entry;
	wire [15:0] opcode;
	wire [32:0] rot_l;
	wire [32:0] rot_r;
	wire setup_rd;
	wire wr_en;
	wire wr_acc;
	wire wr_pc;
	wire wr_status;
	wire exec;
	wire do_push;
	wire do_pop;
	// ====================================================================
	// Bus strobes
	assign pready = 1'b1;
	assign opcode = pwdata[15:0];
	assign setup_rd = psel & ~penable & ~pwrite & ce;
	assign wr_en = psel & penable & pwrite & ce;
	assign wr_acc = wr_en & (paddr == `REG_ACC);
	assign wr_pc = wr_en & (paddr == `REG_PC);
	assign wr_status = wr_en & (paddr == `REG_STATUS);
	assign exec = wr_en & (paddr == `REG_INSTR);
	assign do_push = wr_en & (paddr == `REG_STACK_TOP);
	assign do_pop = exec & (opcode == `OPC_SUB_EXIT);
	assign pslverr = psel & penable & err_d;
	// ====================================================================
	// Status word and mode outputs
	assign status_word_one = {hold_q, fsync_q, carry_q};
	assign frame_sync_mode_bit = fsync_q;
	assign hold_mode_bit = hold_q;
	assign exec_enable = ~(hold_ack & hold_q);
	// ====================================================================
	// Address decode
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `REG_CTRL) || (a == `REG_INSTR) || (a == `REG_ACC) ||
				(a == `REG_PC) || (a == `REG_STATUS) || (a == `REG_STACK_TOP) ||
				(a == `REG_STACK_DEPTH);
		end
	endfunction
	// ====================================================================
	// Program counter step
	function [15:0] pc_step;
		input [15:0] p;
		begin
			pc_step = p + 16'h0001;
		end
	endfunction
	// ====================================================================
	// Rotates through carry, carry out in bit 32
	function [32:0] rot_left;
		input [31:0] a;
		input c;
		begin
			rot_left = {a[31], a[30:0], c};
		end
	endfunction
	function [32:0] rot_right;
		input [31:0] a;
		input c;
		begin
			rot_right = {a[0], c, a[31:1]};
		end
	endfunction
	assign rot_l = rot_left(acc_q, carry_q);
	assign rot_r = rot_right(acc_q, carry_q);
	// ====================================================================
	// Stack depth counting
	function [3:0] depth_up;
		input [3:0] d;
		begin
			if ({28'h0000000, d} < STACK_DEPTH)
				depth_up = d + 4'h1;
			else
				depth_up = d;
		end
	endfunction
	function [3:0] depth_down;
		input [3:0] d;
		begin
			if (d != 4'h0)
				depth_down = d - 4'h1;
			else
				depth_down = d;
		end
	endfunction
	// ====================================================================
	// Read mux and decode error
	always @*
	begin
		err_d = ~is_mapped(paddr);
		case (paddr)
			`REG_INSTR: prdata_d = {16'h0000, instr_q};
			`REG_ACC: prdata_d = acc_q;
			`REG_PC: prdata_d = {16'h0000, pc_q};
			`REG_STATUS: prdata_d = {29'h00000000, status_word_one};
			`REG_STACK_TOP: prdata_d = {16'h0000, stack_top_entry};
			`REG_STACK_DEPTH: prdata_d = {28'h0000000, depth_q};
			default: prdata_d = 32'h00000000;
		endcase
	end
	// ====================================================================
	// Read data, taken in setup so it stands through the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (setup_rd)
			prdata <= prdata_d;
	end
	// ====================================================================
	// Accumulator next value
	always @*
	begin
		acc_d = acc_q;
		if (wr_acc)
			acc_d = pwdata;
		if (exec)
		begin
			case (opcode)
				`OPC_ROT_LEFT: acc_d = rot_l[31:0];
				`OPC_ROT_RIGHT: acc_d = rot_r[31:0];
				default: acc_d = acc_q;
			endcase
		end
	end
	// ====================================================================
	// Program counter next value
	always @*
	begin
		pc_d = pc_q;
		if (wr_pc)
			pc_d = pwdata[15:0];
		if (exec)
		begin
			case (opcode)
				`OPC_SUB_EXIT: pc_d = stack_top_entry;
				`OPC_CARRY_CLEAR: pc_d = pc_step(pc_q);
				`OPC_HOLD_CLEAR: pc_d = pc_step(pc_q);
				default: pc_d = pc_step(pc_q);
			endcase
		end
	end
	// ====================================================================
	// Status flags next values
	always @*
	begin
		carry_d = carry_q;
		fsync_d = fsync_q;
		hold_d = hold_q;
		if (wr_status)
		begin
			carry_d = pwdata[`ST_CARRY];
			fsync_d = pwdata[`ST_FSYNC];
			hold_d = pwdata[`ST_HOLD];
		end
		if (exec)
		begin
			case (opcode)
				`OPC_CARRY_CLEAR: carry_d = 1'b0;
				`OPC_FSYNC_CLEAR: fsync_d = 1'b0;
				`OPC_HOLD_CLEAR: hold_d = 1'b0;
				`OPC_ROT_LEFT: carry_d = rot_l[32];
				`OPC_ROT_RIGHT: carry_d = rot_r[32];
				default: carry_d = carry_q;
			endcase
		end
	end
	// ====================================================================
	// Stack depth and last instruction next values
	always @*
	begin
		depth_d = depth_q;
		instr_d = instr_q;
		if (do_push)
			depth_d = depth_up(depth_q);
		if (do_pop)
			depth_d = depth_down(depth_q);
		if (exec)
			instr_d = opcode;
	end
	// ====================================================================
	// Accumulator register
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			acc_q <= `RST_ACC;
		else if (ce)
			acc_q <= acc_d;
	end
	// ====================================================================
	// Program counter register
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pc_q <= `RST_PC;
		else if (ce)
			pc_q <= pc_d;
	end
	// ====================================================================
	// Carry flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			carry_q <= `RST_CARRY;
		else if (ce)
			carry_q <= carry_d;
	end
	// ====================================================================
	// Frame sync mode flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fsync_q <= `RST_FSYNC;
		else if (ce)
			fsync_q <= fsync_d;
	end
	// ====================================================================
	// Hold mode flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold_q <= `RST_HOLD;
		else if (ce)
			hold_q <= hold_d;
	end
	// ====================================================================
	// Last instruction register
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			instr_q <= `RST_INSTR;
		else if (ce)
			instr_q <= instr_d;
	end
	// ====================================================================
	// Stack depth register
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			depth_q <= `RST_DEPTH;
		else if (ce)
			depth_q <= depth_d;
	end
	// ====================================================================
	// Return stack
	hw_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(16)
	) u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.push(do_push),
		.pop(do_pop),
		.push_data(pwdata[15:0]),
		.stack_top_entry(stack_top_entry)
	);
endmodule // status_clear_rotate_return_ops
`default_nettype wire

// file: status_ops_assertions.sv
// Checker for the clear operations, run enable and slave error, with a cover of the return operation
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// Port checker
module status_ops_checker(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pslverr,
	input wire logic hold_ack,
	input wire logic frame_sync_mode_bit,
	input wire logic hold_mode_bit,
	input wire logic exec_enable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire wr = psel&&penable&&ce&&pwrite&&paddr==12'h004;
wire [15:0] op = pwdata[15:0];
property p_cc; wr&&op==16'hCE30 ##3 psel&&penable&&!pwrite&&paddr==12'h010 |=> !prdata[0]; endproperty
a_cc: assert property(p_cc) else $error("carry still set");
property p_keep; wr&&op==16'hCE30 |=> $stable(frame_sync_mode_bit)&&$stable(hold_mode_bit); endproperty
a_keep: assert property(p_keep) else $error("mode bits moved");
property p_fs; wr&&op==16'hCE36 |=> !frame_sync_mode_bit; endproperty
a_fs: assert property(p_fs) else $error("frame sync bit set");
property p_fz; !frame_sync_mode_bit&&!(psel&&penable&&ce&&pwrite&&paddr==12'h010) |=> !frame_sync_mode_bit; endproperty
a_fz: assert property(p_fz) else $error("frame sync bit rose");
property p_hm; wr&&op==16'hCE38 |=> !hold_mode_bit; endproperty
a_hm: assert property(p_hm) else $error("hold bit set");
property p_ex; exec_enable==!(hold_ack&&hold_mode_bit); endproperty
a_ex: assert property(p_ex) else $error("run enable wrong");
property p_er; psel&&penable&&paddr>12'h018 |-> pslverr; endproperty
a_er: assert property(p_er) else $error("no slave error");
property p_ne; !psel |-> !pslverr; endproperty
a_ne: assert property(p_ne) else $error("stray slave error");
c_hold: cover property(hold_ack&&!exec_enable);
c_ret: cover property(wr&&op==16'hCE26);
c_err: cover property(pslverr);
endmodule // status_ops_checker
bind status_clear_rotate_return_ops status_ops_checker u_chk(.*);
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the clear, rotate and return operations
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic pclk=0,presetn=0,ce=1,psel=0,penable=0,pwrite=0,hold_ack=0,se,pready,pslverr,fs,hm,ex;
logic [11:0] paddr=0;
logic [31:0] pwdata=0,prdata,rd,acc=0,v;
logic [2:0] st=3'h7;
logic [15:0] pc=0;
logic [15:0] ops[6]='{16'hCE30,16'hCE26,16'hCE36,16'hCE38,16'hCE34,16'hCE35};
logic [15:0] stk[$];
int err_count=0,tests_run=0;
always #5 pclk=~pclk;
status_clear_rotate_return_ops DUT(.pclk(pclk),.presetn(presetn),.ce(ce),.psel(psel),.penable(penable),
	.pwrite(pwrite),.paddr(paddr),.pwdata(pwdata),.prdata(prdata),.pready(pready),.pslverr(pslverr),
	.hold_ack(hold_ack),.frame_sync_mode_bit(fs),.hold_mode_bit(hm),.exec_enable(ex));
// ====================================================================
// Helpers
function [32:0] rot(input l,input [32:0] x);
	return l?{x[31:0],x[32]}:{x[0],x[32:1]};
endfunction
task apb(input w,input [11:0] a,input [31:0] d);
	@(posedge pclk);
	psel<=1;
	pwrite<=w;
	paddr<=a;
	pwdata<=d;
	@(posedge pclk);
	penable<=1;
	do @(posedge pclk); while (pready!==1'b1);
	se=pslverr;
	rd=prdata;
	psel<=0;
	penable<=0;
endtask
task chk(input [11:0] a,input [31:0] e);
	apb(0,a,0);
	tests_run++;
	if ({se,rd,ex}!=={a>12'h018,e,!(hold_ack&&st[2])})
	begin
		$display("mismatch reg %h exp %h got %h",a,{a>12'h018,e,!(hold_ack&&st[2])},{se,rd,ex});
		err_count++;
	end
endtask
task ins(input [15:0] o);
	apb(1,12'h004,{16'h0,o});
	pc=pc+1;
	case (o)
		16'hCE30: st[0]=0;
		16'hCE36: st[1]=0;
		16'hCE38: st[2]=0;
		16'hCE34: {st[0],acc}=rot(1,{st[0],acc});
		16'hCE35: {st[0],acc}=rot(0,{st[0],acc});
		16'hCE26: pc=stk.pop_front();
		default: ;
	endcase
endtask
task end_of_test;
	if (err_count==0&&tests_run>0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
// ====================================================================
// Sequence
initial
begin
	#200000;
	err_count++;
	end_of_test;
end
initial
begin
	v=$urandom(43971);
	repeat(5) @(posedge pclk);
	presetn<=1;
	chk(12'h010,32'h7);
	chk(12'h00C,0);
	chk(12'h01C,0);
	for (int i=0;i<36;i++)
	begin
		v=$urandom;
		hold_ack<=v[3];
		acc=$urandom;
		apb(1,12'h008,acc);
		st=v[2:0];
		apb(1,12'h010,{29'h0,st});
		apb(1,12'h014,{16'h0,v[31:16]});
		stk.push_front(v[31:16]);
		if (stk.size()>8)
			stk=stk[0:7];
		ins(ops[i%6]);
		chk(12'h010,{29'h0,st});
		chk(12'h008,acc);
		chk(12'h00C,{16'h0,pc});
		chk(12'h018,32'(stk.size()));
	end
	ce<=0;
	apb(1,12'h008,~acc);
	ce<=1;
	chk(12'h008,acc);
	presetn<=0;
	@(posedge pclk);
	presetn<=1;
	st=3'h7;
	acc=0;
	pc=0;
	stk.delete();
	chk(12'h010,32'h7);
	chk(12'h018,0);
	chk(12'h00C,0);
	chk(12'h008,0);
	end_of_test;
end
endmodule // tb_top
`default_nettype wire
